// ==== dv/psm_properties.sv ====
// Purpose: Assertions on pin ownership and read-back
// Assumes: One clock, async active-low reset
// Notes:   Bound into psm_top
`timescale 1ns/1ps
module psm_props #(
  parameter int unsigned PINS = 4
) (
  input wire logic            MCLK,
  input wire logic            RST_B,
  input wire logic [PINS-1:0] PIN_O,
  input wire logic [PINS-1:0] PIN_OE,
  input wire logic [PINS-1:0] PIN_PULLUP,
  input wire logic [PINS-1:0] LATCH,
  input wire logic [PINS-1:0] CFG_WE,
  input wire logic [7:0]      CFG_WDATA,
  input wire logic            SPI_EN,
  input wire logic            SPI_MASTER,
  input wire logic            SPI_SS_USE,
  input wire logic            SPI_MOSI_OUT,
  input wire logic            SPI_MISO_OUT,
  input wire logic [7:0]      CFG_RD,
  input wire logic [7:0]      STATUS_RD
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  sequence s_mst; SPI_EN && SPI_MASTER; endsequence
  sequence s_slv; SPI_EN && !SPI_MASTER; endsequence
  property p_rst; $rose(RST_B) |-> PIN_OE == '0 && PIN_PULLUP == '0; endproperty
  property p_mosi_m; s_mst |=> PIN_OE[0] && PIN_O[0] == $past(SPI_MOSI_OUT); endproperty
  property p_mosi_s; s_slv |=> !PIN_OE[0]; endproperty
  property p_miso_m; s_mst |=> !PIN_OE[1]; endproperty
  property p_miso_s; s_slv |=> PIN_OE[1] && PIN_O[1] == $past(SPI_MISO_OUT); endproperty
  property p_clk_m; s_mst |=> PIN_OE[3] && STATUS_RD[3]; endproperty
  property p_clk_s; s_slv |=> !PIN_OE[3] && !STATUS_RD[3]; endproperty
  property p_ss; SPI_EN && SPI_SS_USE |=> !PIN_OE[2]; endproperty
  property p_fixed; $past(RST_B) |-> STATUS_RD[7:6] == 2'h2; endproperty
  property p_cfg; CFG_WE[1] |=> CFG_RD[3:2] == $past(CFG_WDATA[3:2]); endproperty
  // Mode register lags its read-back by nothing, pin lags by one edge
  property p_push; !SPI_EN && CFG_RD[1:0] == 2'h1 |=> PIN_OE[0] && PIN_O[0] == $past(LATCH[0]); endproperty
  a_rst: assert property (p_rst) else $error("pins active after reset");
  a_mosi_m: assert property (p_mosi_m) else $error("mosi not driven");
  a_mosi_s: assert property (p_mosi_s) else $error("mosi driven");
  a_miso_m: assert property (p_miso_m) else $error("miso driven");
  a_miso_s: assert property (p_miso_s) else $error("miso not driven");
  a_clk_m: assert property (p_clk_m) else $error("clock not driven");
  a_clk_s: assert property (p_clk_s) else $error("clock driven");
  a_ss: assert property (p_ss) else $error("select driven");
  a_fixed: assert property (p_fixed) else $error("fixed bits wrong");
  a_cfg: assert property (p_cfg) else $error("mode lost");
  a_push: assert property (p_push) else $error("push pin wrong");
endmodule // psm_props

bind psm_top psm_props #(.PINS(PINS)) psm_props_i (.MCLK(MCLK), .RST_B(RST_B),
  .PIN_O(PIN_O), .PIN_OE(PIN_OE), .PIN_PULLUP(PIN_PULLUP), .LATCH(LATCH),
  .CFG_WE(CFG_WE), .CFG_WDATA(CFG_WDATA), .SPI_EN(SPI_EN),
  .SPI_MASTER(SPI_MASTER), .SPI_SS_USE(SPI_SS_USE),
  .SPI_MOSI_OUT(SPI_MOSI_OUT), .SPI_MISO_OUT(SPI_MISO_OUT),
  .CFG_RD(CFG_RD), .STATUS_RD(STATUS_RD));

// ==== dv/psm_spi_peer.sv ====
// Purpose: External SPI device on the four pads
// Assumes: Port pad drive (PIN_OE) wins any clash
// Notes:   Undriven lines without pull-up toggle so stale values never pass
`timescale 1ns/1ps
module psm_spi_peer (
  input  wire logic       MCLK,
  input  wire logic       DEV_EN,
  input  wire logic       DEV_MASTER,
  input  wire logic [3:0] PIN_O,
  input  wire logic [3:0] PIN_OE,
  input  wire logic [3:0] PIN_PULLUP,
  output      logic [3:0] PIN_I
);
  logic [3:0] drv;
  logic [3:0] pat = 4'h5;
  always @(posedge MCLK) pat <= ~pat;
  // Peer as slave answers on data back; as master drives the rest
  assign drv = !DEV_EN ? 4'h0 : DEV_MASTER ? 4'h2 : 4'hd;
  assign PIN_I = (PIN_OE & PIN_O)
               | (~PIN_OE & ((drv & pat) | (~drv & (PIN_PULLUP | ~pat))));
endmodule // psm_spi_peer

// ==== dv/tb_top.sv ====
// Purpose: Random and corner checks of pin ownership
// Assumes: Expectations from bench model of modes
// Notes:   Pull-up checked on every pin, expected off on SPI-driven pins
`timescale 1ns/1ps
module tb_top;
  logic        MCLK, RST_B, SPI_EN, SPI_MASTER, SPI_SS_USE;
  logic        SPI_MOSI_OUT, SPI_MISO_OUT, SPI_CLK_OUT;
  logic [3:0]  PIN_I, PIN_O, PIN_OE, PIN_PULLUP, LATCH, CFG_WE;
  logic [7:0]  CFG_WDATA, CFG_RD, STATUS_RD;
  logic [15:0] lf;
  logic [11:0] ex;
  logic [4:0]  ex2;
  logic        ss_in;
  logic [1:0]  md [4];
  int          err_total, compares;

  psm_top psm_top_i (.MCLK(MCLK), .RST_B(RST_B), .PIN_I(PIN_I),
    .PIN_O(PIN_O), .PIN_OE(PIN_OE), .PIN_PULLUP(PIN_PULLUP), .LATCH(LATCH),
    .CFG_WE(CFG_WE), .CFG_WDATA(CFG_WDATA), .SPI_EN(SPI_EN),
    .SPI_MASTER(SPI_MASTER), .SPI_SS_USE(SPI_SS_USE),
    .SPI_MOSI_OUT(SPI_MOSI_OUT), .SPI_MISO_OUT(SPI_MISO_OUT),
    .SPI_CLK_OUT(SPI_CLK_OUT), .SPI_MOSI_IN(), .SPI_MISO_IN(),
    .SPI_CLK_IN(), .SPI_SS_IN(ss_in), .PORT_RD(), .CFG_RD(CFG_RD),
    .STATUS_RD(STATUS_RD));
  psm_spi_peer psm_spi_peer_i (.MCLK(MCLK), .DEV_EN(SPI_EN),
    .DEV_MASTER(SPI_MASTER), .PIN_O(PIN_O), .PIN_OE(PIN_OE),
    .PIN_PULLUP(PIN_PULLUP), .PIN_I(PIN_I));

  function automatic logic [15:0] nx(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Returns {owned, enable, value under enable}
  function automatic logic [11:0] expv();
    logic [3:0] own, oe, sv;
    logic       inp;
    sv = {SPI_CLK_OUT, 1'b0, SPI_MISO_OUT, SPI_MOSI_OUT};
    for (int i = 0; i < 4; i++) begin
      own[i] = SPI_EN && (i == 1 ? !SPI_MASTER : i != 2 && SPI_MASTER);
      inp = SPI_EN && (i == 1 ? SPI_MASTER : i == 2 ? SPI_SS_USE : !SPI_MASTER);
      oe[i] = own[i] || (!inp && (md[i] == 2'h1 || (md[i] != 2'h2 && !LATCH[i])));
    end
    return {own, oe, (own & sv | ~own & LATCH) & oe};
  endfunction

  // Returns {select unused, pull-up per pin}
  function automatic logic [4:0] expp();
    logic [3:0] pu;
    logic       own, inp;
    for (int i = 0; i < 4; i++) begin
      own = SPI_EN && (i == 1 ? !SPI_MASTER : i != 2 && SPI_MASTER);
      inp = SPI_EN && (i == 1 ? SPI_MASTER : i == 2 ? SPI_SS_USE : !SPI_MASTER);
      pu[i] = !own && md[i] == 2'h0 && (inp || LATCH[i]);
    end
    return {!(SPI_EN && SPI_SS_USE), pu};
  endfunction

  task automatic chk(logic [11:0] g, logic [11:0] x);
    compares++;
    if (g !== x) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic give_verdict();
    $display("err_total=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  // Hang guard; the run itself is about 420 cycles
  initial begin
    #20000;
    err_total++;
    give_verdict();
  end

  initial begin
    {RST_B, SPI_EN, SPI_MASTER, SPI_SS_USE} = 4'h0;
    {SPI_MOSI_OUT, SPI_MISO_OUT, SPI_CLK_OUT} = 3'h0;
    LATCH = 4'h0;
    CFG_WE = 4'h0;
    CFG_WDATA = 8'h00;
    lf = 16'h0010;
    md = '{2'h2, 2'h2, 2'h2, 2'h2};
    repeat (20) @(posedge MCLK);
    RST_B <= 1'b1;
    @(negedge MCLK);
    chk({4'h0, PIN_OE, PIN_PULLUP}, 12'h000);
    @(negedge MCLK);
    chk({4'h0, CFG_RD}, 12'h0aa);
    chk({8'h00, STATUS_RD[7:4]}, 12'h008);
    for (int n = 0; n < 400; n++) begin
      @(posedge MCLK);
      ex = expv();
      ex2 = expp();
      for (int i = 0; i < 4; i++)
        if (CFG_WE[i]) md[i] = CFG_WDATA[2*i +: 2];
      lf = nx(nx(lf));
      {SPI_EN, SPI_MASTER, SPI_SS_USE, SPI_MOSI_OUT} <= lf[3:0];
      {SPI_MISO_OUT, SPI_CLK_OUT} <= lf[5:4];
      LATCH <= lf[9:6];
      // First write sets every pin push-pull, so SPI takeover is visible
      CFG_WE <= n == 0 ? 4'hf : lf[13:10] & {4{lf[14]}};
      CFG_WDATA <= n == 0 ? 8'h55 : lf[15:8];
      @(negedge MCLK);
      chk({STATUS_RD[3:0], PIN_OE, PIN_O & PIN_OE}, ex);
      chk({4'h0, CFG_RD}, {4'h0, md[3], md[2], md[1], md[0]});
      chk({7'h0, ex2[4] ? ss_in : 1'b1, PIN_PULLUP}, {7'h0, 1'b1, ex2[3:0]});
    end
    give_verdict();
  end
endmodule // tb_top

// ==== rtl/psm_pkg.sv ====
// Purpose: Shared constants and types for the SPI pin multiplexer
// Assumes: Four port pins, index 0..3 maps to port_b_bit_two..five
// Notes:   Mode encodings are local to this block

package psm_pkg;

  localparam int unsigned PIN_COUNT = 4;

  // Pin positions inside the four-bit port
  localparam int unsigned MOSI_IDX = 0; // port_b_bit_two
  localparam int unsigned MISO_IDX = 1; // port_b_bit_three
  localparam int unsigned SS_IDX   = 2; // port_b_bit_four
  localparam int unsigned SCLK_IDX = 3; // port_b_bit_five, serial_clock_pin

  // Per-pin output driver type
  typedef enum logic [1:0] {
    PSM_QUASI  = 2'h0,
    PSM_PUSH   = 2'h1,
    PSM_INPUT  = 2'h2,
    PSM_ODRAIN = 2'h3
  } psm_mode_t;

  localparam psm_mode_t MODE_RST = PSM_INPUT;

  // Field width of one pin's mode in the config write and read words
  localparam int unsigned MODE_W = 2;

  // Reset values of pin drive registers and input synchronisers
  localparam logic [3:0] PIN_O_RST  = 4'h0;
  localparam logic [3:0] PIN_OE_RST = 4'h0;
  localparam logic [3:0] PIN_PU_RST = 4'h0;
  localparam logic       SYNC_RST   = 1'h0;

  // Status read word layout
  localparam int unsigned ST_ONE_BIT  = 7;
  localparam int unsigned ST_ZERO_BIT = 6;
  localparam int unsigned ST_RSV_HI   = 5;
  localparam int unsigned ST_RSV_LO   = 4;
  localparam int unsigned ST_OWN_LO   = 0;
  localparam logic [1:0]  ST_RSV_VAL  = 2'h0;

endpackage

// ==== rtl/psm_sync.sv ====
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pins are asynchronous to MCLK
// Notes:   First stage feeds only the second stage

`timescale 1ns/1ps

module psm_sync (
  input  wire logic MCLK,
  input  wire logic RST_B,
  psm_sync_if.sync  sif
);

  localparam int unsigned W = $bits(sif.raw);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] clean_ff;
  logic [W-1:0] nxt_clean;

  // A change counts only once stages two and three agree
  always_comb begin
    nxt_clean = clean_ff;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_clean[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      s1_ff    <= {W{psm_pkg::SYNC_RST}};
      s2_ff    <= {W{psm_pkg::SYNC_RST}};
      s3_ff    <= {W{psm_pkg::SYNC_RST}};
      clean_ff <= {W{psm_pkg::SYNC_RST}};
    end else begin
      s1_ff    <= sif.raw;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      clean_ff <= nxt_clean;
    end
  end

  assign sif.clean = clean_ff;

endmodule // psm_sync

// ==== rtl/psm_sync_if.sv ====
// Purpose: Carries raw pin levels to the synchroniser and clean ones back
// Assumes: One clock domain on the user side
// Notes:   Width set by parameter

`timescale 1ns/1ps

interface psm_sync_if #(
  parameter int unsigned W = 4
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;

  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// ==== rtl/psm_top.sv ====
// Purpose: Four-pin port whose pins double as SPI data, select and clock
// Assumes: SPI core and port latches sit on MCLK; pins are asynchronous
// Notes:   Pin drive registered, one cycle after an SPI or latch change, two after a mode write
//
// Functional notes
// - Four-pin port, each pin's output driver type chosen by software
// - In reset every pin is input only with pull-up off
// - Each pin keeps its own mode; writing one leaves others alone
// - MOSI pin driven when SPI is master, input when slave
// - MISO pin input when SPI is master, driven when slave
// - Serial clock pin driven when master, received as input when slave
// - Reserved bits written zero; device may return anything on read
// - Fixed-zero bits written zero and always read back zero
// - Fixed-one bits written one and always read back one (status reads zero in reset, until the first clock after it)

`timescale 1ns/1ps

module psm_top #(
  parameter int unsigned PINS = psm_pkg::PIN_COUNT
) (
  input  wire logic            MCLK,
  input  wire logic            RST_B,
  // Pad side
  input  wire logic [PINS-1:0] PIN_I,
  output      logic [PINS-1:0] PIN_O,
  output      logic [PINS-1:0] PIN_OE,
  output      logic [PINS-1:0] PIN_PULLUP,
  // Port latch and per-pin configuration
  input  wire logic [PINS-1:0] LATCH,
  input  wire logic [PINS-1:0] CFG_WE,
  input  wire logic [7:0]      CFG_WDATA,
  // SPI core side
  input  wire logic            SPI_EN,
  input  wire logic            SPI_MASTER,
  input  wire logic            SPI_SS_USE,
  input  wire logic            SPI_MOSI_OUT,
  input  wire logic            SPI_MISO_OUT,
  input  wire logic            SPI_CLK_OUT,
  output      logic            SPI_MOSI_IN,
  output      logic            SPI_MISO_IN,
  output      logic            SPI_CLK_IN,
  output      logic            SPI_SS_IN,
  // Read-back
  output      logic [PINS-1:0] PORT_RD,
  output      logic [7:0]      CFG_RD,
  output      logic [7:0]      STATUS_RD
);

  psm_sync_if #(.W(PINS)) sif ();

  psm_pkg::psm_mode_t cfg_ff      [PINS];
  psm_pkg::psm_mode_t nxt_cfg     [PINS];
  logic [PINS-1:0]    pin_o_ff;
  logic [PINS-1:0]    pin_oe_ff;
  logic [PINS-1:0]    pin_pu_ff;
  logic [PINS-1:0]    nxt_pin_o;
  logic [PINS-1:0]    nxt_pin_oe;
  logic [PINS-1:0]    nxt_pin_pu;
  logic [PINS-1:0]    spi_drv;
  logic [PINS-1:0]    spi_rcv;
  logic [PINS-1:0]    spi_val;
  logic [PINS-1:0]    nxt_spi_in;
  logic [PINS-1:0]    spi_in_ff;
  logic [7:0]         nxt_status;
  logic [7:0]         status_ff;
  logic [7:0]         nxt_cfg_rd;
  logic [7:0]         cfg_rd_ff;

  assign sif.raw = PIN_I;

  psm_sync u_sync (
    .MCLK  (MCLK),
    .RST_B (RST_B),
    .sif   (sif)
  );

  // Which pins the SPI owns, and in which direction
  always_comb begin
    spi_drv = '0;
    spi_rcv = '0;
    spi_val = '0;
    if (SPI_EN) begin
      spi_val[psm_pkg::MOSI_IDX] = SPI_MOSI_OUT;
      spi_val[psm_pkg::MISO_IDX] = SPI_MISO_OUT;
      spi_val[psm_pkg::SCLK_IDX] = SPI_CLK_OUT;
      if (SPI_MASTER) begin
        spi_drv[psm_pkg::MOSI_IDX] = 1'b1;
        spi_rcv[psm_pkg::MISO_IDX] = 1'b1;
        spi_drv[psm_pkg::SCLK_IDX] = 1'b1;
      end else begin
        spi_rcv[psm_pkg::MOSI_IDX] = 1'b1;
        spi_drv[psm_pkg::MISO_IDX] = 1'b1;
        spi_rcv[psm_pkg::SCLK_IDX] = 1'b1;
      end
      spi_rcv[psm_pkg::SS_IDX] = SPI_SS_USE;
    end
  end

  // Per-pin mode storage and driver selection
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    logic g_o;
    logic g_oe;
    logic g_pu;

    always_comb begin
      nxt_cfg[i] = cfg_ff[i];
      if (CFG_WE[i]) begin
        nxt_cfg[i] = psm_pkg::psm_mode_t'(
          CFG_WDATA[i*psm_pkg::MODE_W +: psm_pkg::MODE_W]);
      end
    end

    always_comb begin
      g_o  = 1'b0;
      g_oe = 1'b0;
      g_pu = 1'b0;
      if (spi_drv[i]) begin
        // SPI outputs are always actively driven, whatever the mode
        g_o  = spi_val[i];
        g_oe = 1'b1;
      end else if (spi_rcv[i]) begin
        // Keep the weak pull-up of a quasi pin so a floating input idles
        g_pu = (cfg_ff[i] == psm_pkg::PSM_QUASI);
      end else begin
        case (cfg_ff[i])
          psm_pkg::PSM_QUASI: begin
            g_oe = ~LATCH[i];
            g_pu = LATCH[i];
          end
          psm_pkg::PSM_PUSH: begin
            g_o  = LATCH[i];
            g_oe = 1'b1;
          end
          psm_pkg::PSM_ODRAIN: begin
            g_oe = ~LATCH[i];
          end
          psm_pkg::PSM_INPUT: begin
            g_oe = 1'b0;
          end
          default: begin
            g_oe = 1'b0;
          end
        endcase
      end
    end

    assign nxt_pin_o[i]  = g_o;
    assign nxt_pin_oe[i] = g_oe;
    assign nxt_pin_pu[i] = g_pu;
    assign nxt_cfg_rd[i*psm_pkg::MODE_W +: psm_pkg::MODE_W] = nxt_cfg[i];

    always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
        cfg_ff[i] <= psm_pkg::MODE_RST;
      end else begin
        cfg_ff[i] <= nxt_cfg[i];
      end
    end
  end

  // SPI inputs read the cleaned pin; a driven pin reads back as idle
  always_comb begin
    nxt_spi_in = sif.clean & spi_rcv;
    if (!spi_rcv[psm_pkg::SS_IDX]) begin
      // Unused select reads inactive high so the slave is not selected
      nxt_spi_in[psm_pkg::SS_IDX] = 1'b1;
    end
  end

  // Fixed bits read their value from the first clock after reset; reserved bits read zero
  always_comb begin
    nxt_status = '0;
    nxt_status[psm_pkg::ST_ONE_BIT]  = 1'b1;
    nxt_status[psm_pkg::ST_ZERO_BIT] = 1'b0;
    nxt_status[psm_pkg::ST_RSV_HI:psm_pkg::ST_RSV_LO] =
      psm_pkg::ST_RSV_VAL;
    nxt_status[psm_pkg::ST_OWN_LO +: PINS] = spi_drv;
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_o_ff  <= psm_pkg::PIN_O_RST;
      pin_oe_ff <= psm_pkg::PIN_OE_RST;
      pin_pu_ff <= psm_pkg::PIN_PU_RST;
      spi_in_ff <= '0;
      status_ff <= '0;
      cfg_rd_ff <= '0;
    end else begin
      pin_o_ff  <= nxt_pin_o;
      pin_oe_ff <= nxt_pin_oe;
      pin_pu_ff <= nxt_pin_pu;
      spi_in_ff <= nxt_spi_in;
      status_ff <= nxt_status;
      cfg_rd_ff <= nxt_cfg_rd;
    end
  end

  // Reset clears the pad drive at once, not after a clock
  assign PIN_O      = pin_o_ff;
  assign PIN_OE     = pin_oe_ff;
  assign PIN_PULLUP = pin_pu_ff;

  assign SPI_MOSI_IN = spi_in_ff[psm_pkg::MOSI_IDX];
  assign SPI_MISO_IN = spi_in_ff[psm_pkg::MISO_IDX];
  assign SPI_CLK_IN  = spi_in_ff[psm_pkg::SCLK_IDX];
  assign SPI_SS_IN   = spi_in_ff[psm_pkg::SS_IDX];

  assign PORT_RD   = sif.clean;
  assign CFG_RD    = cfg_rd_ff;
  assign STATUS_RD = status_ff;

endmodule // psm_top
